// ===== logic/sfb_link.sv
//----------------------------------------------------------------------
// Purpose : Device end of the four-wire serial flash command link
// Assumes : Serial clock comes from the host and stops between frames
// Notes   : Link logic on spi_clk_i, user side on ref_clk_i
//
// Functional notes
// - Output on falling edge, input on rising
// - Whole input byte before first output bit
// - Decode 0BH, E8H, 03H array reads
// - Decode D4H, D6H buffer reads
// - Decode D1H, D3H slow buffer reads
// - Decode D2H direct page read
// - Decode 32H, 35H, 77H register reads
// - Decode D7H status, 9FH identification reads
// - Page size 264 by default, 256 optional
// - Serial clock modes 0 and 3 accepted
//----------------------------------------------------------------------
`timescale 1ns/1ps
module sfb_link #(
    parameter logic [31:0] ID_CODE = 32'h5AA50FF0, // Arbitrary value
    parameter int          ID_LEN  = 4
) (
    // Core clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         srst_i,
    // Serial link pins
    input  wire logic         spi_clk_i,
    input  wire logic         cs_n_i,
    input  wire logic         si_i,
    output logic              so_o,
    output logic              so_oe_n_o,
    // Received byte stream
    output logic              rx_valid_o,
    output logic              rx_first_o,
    output logic [7:0]        rx_data_o,
    output logic              cmd_valid_o,
    output sfb_pkg::sfb_cmd_e cmd_class_o,
    // Output byte supply
    output logic              tx_req_o,
    input  wire logic         tx_valid_i,
    input  wire logic [7:0]   tx_data_i,
    // Status and page configuration
    input  wire logic [7:0]   status_i,
    input  wire logic         page_pow2_set_i,
    output logic [8:0]        page_size_o,
    output logic              frame_active_o
);

    //------------------------------------------------------------------
    // Parameter checks
    //------------------------------------------------------------------
    if (ID_LEN < 1 || ID_LEN > sfb_pkg::ID_LEN_MAX) begin : g_chk
        $error("sfb_link: ID_LEN out of range");
    end

    //------------------------------------------------------------------
    // State types
    //------------------------------------------------------------------
    // Link side, clocked on rising serial clock
    typedef struct packed {
        logic [2:0] bit_cnt;  // Bits taken in this byte
        logic [2:0] byte_idx; // Bytes done, saturating
        logic [6:0] in_shift; // Partial input byte
        logic [8:0] rx_word;  // First flag and byte
        logic       rx_tgl;   // Flips per byte taken
        logic       req_tgl;  // Flips per byte asked for
        logic       imm_stat; // Frame serves status
        logic       imm_id;   // Frame serves identity
        logic [7:0] tx_shift; // Output byte, MSB first
    } sfb_link_s;

    // Core side, clocked on ref_clk_i
    typedef struct packed {
        logic              rx_seen;
        logic              req_seen;
        logic              rx_valid;
        logic              rx_first;
        logic [7:0]        rx_data;
        logic              cmd_valid;
        sfb_pkg::sfb_cmd_e cmd_class;
        logic              tx_pend;
        logic              req_tag;
        logic              ack_tgl;
        logic [7:0]        tx_hold;
        logic [7:0]        stat_hold;
        logic              pow2;
        logic              frame;
    } sfb_core_s;

    localparam sfb_link_s LK_RST = '{
        tx_shift: sfb_pkg::FILL_BYTE,
        default:  '0
    };

    //------------------------------------------------------------------
    // Signals
    //------------------------------------------------------------------
    sfb_link_s         lk_reg;
    sfb_link_s         lk_next;
    sfb_core_s         co_reg;
    sfb_core_s         co_next;
    logic              frame_rst;
    logic              armed_reg;
    logic              so_reg;
    logic [7:0]        stat_lk;
    logic              ack_lk;
    logic              cs_n_co;
    logic              rx_co;
    logic              req_co;
    logic [2:0]        eff_cnt;
    logic [2:0]        eff_idx;
    logic              is_op;
    logic [7:0]        in_byte;
    logic [31:0]       id_word;
    logic              id_ok;
    logic              use_stat;
    logic              use_id;
    logic [7:0]        next_byte;
    sfb_pkg::sfb_cmd_e lk_class;
    sfb_pkg::sfb_cmd_e co_class;

    //------------------------------------------------------------------
    // Crossings
    //------------------------------------------------------------------
    // Status snapshot and answer tag into the link domain
    sfb_sync #(
        .W (9)
    ) u_lk_sync (
        .clk_i (spi_clk_i),
        .d_i   ({co_reg.stat_hold, co_reg.ack_tgl}),
        .q_o   ({stat_lk, ack_lk})
    );

    // Select and both toggles into the core domain
    sfb_sync #(
        .W (3)
    ) u_co_sync (
        .clk_i (ref_clk_i),
        .d_i   ({cs_n_i, lk_reg.rx_tgl, lk_reg.req_tgl}),
        .q_o   ({cs_n_co, rx_co, req_co})
    );

    //------------------------------------------------------------------
    // Decoders
    //------------------------------------------------------------------
    // Link copy picks frames answered locally
    sfb_opdec u_lk_dec (
        .opcode_i    (in_byte),
        .cmd_class_o (lk_class)
    );

    // Core copy reports the class to the user
    sfb_opdec u_co_dec (
        .opcode_i    (lk_reg.rx_word[7:0]),
        .cmd_class_o (co_class)
    );

    //------------------------------------------------------------------
    // Frame start
    //------------------------------------------------------------------
    // Deselect or reset arms the frame start and idles the output; safe as cs is high at reset
    assign frame_rst = cs_n_i | srst_i;

    // Set while deselected, cleared at first rising edge
    always_ff @(posedge spi_clk_i or posedge frame_rst) begin
        if (frame_rst) begin
            armed_reg <= 1'b1;
        end else begin
            armed_reg <= 1'b0;
        end
    end

    // Counters restart on the first edge, whatever the idle level
    assign eff_cnt = armed_reg ? 3'h0 : lk_reg.bit_cnt;
    assign eff_idx = armed_reg ? 3'h0 : lk_reg.byte_idx;
    assign is_op   = (eff_idx == 3'h0);

    //------------------------------------------------------------------
    // Next output byte
    //------------------------------------------------------------------
    // Input sampled on the rising edge
    assign in_byte = {lk_reg.in_shift, si_i};

    // Status and identity bytes answered without the core
    assign use_stat = is_op ? (lk_class == sfb_pkg::CMD_STAT_RD)
                            : lk_reg.imm_stat;
    assign use_id   = is_op ? (lk_class == sfb_pkg::CMD_ID_RD)
                            : lk_reg.imm_id;
    assign id_word  = ID_CODE << {eff_idx, 3'h0};
    assign id_ok    = int'(eff_idx) < ID_LEN;

    // Core byte only when its answer tag matches the last request
    always_comb begin
        if (use_stat) begin
            next_byte = stat_lk;
        end else if (use_id) begin
            next_byte = id_ok ? id_word[31:24] : sfb_pkg::FILL_BYTE;
        end else if (ack_lk == lk_reg.req_tgl) begin
            next_byte = co_reg.tx_hold;
        end else begin
            next_byte = sfb_pkg::FILL_BYTE;
        end
    end

    //------------------------------------------------------------------
    // Link domain state
    //------------------------------------------------------------------
    // Shift in, count, hand bytes over, load output
    always_comb begin
        lk_next          = lk_reg;
        lk_next.bit_cnt  = eff_cnt + 3'h1;
        lk_next.byte_idx = eff_idx;
        lk_next.in_shift = in_byte[6:0];
        lk_next.tx_shift = {lk_reg.tx_shift[6:0], 1'b1};
        // Ask the core for the following byte at slot start
        if (eff_cnt == 3'h0) begin
            lk_next.req_tgl = ~lk_reg.req_tgl;
        end
        // Byte complete: output starts only now
        if (eff_cnt == sfb_pkg::BIT_LAST) begin
            lk_next.rx_word = {is_op, in_byte};
            lk_next.rx_tgl  = ~lk_reg.rx_tgl;
            if (eff_idx != sfb_pkg::IDX_MAX) begin
                lk_next.byte_idx = eff_idx + 3'h1;
            end
            if (is_op) begin
                lk_next.imm_stat = use_stat;
                lk_next.imm_id   = use_id;
            end
            lk_next.tx_shift = next_byte;
        end
        // Edges while deselected leave the link state alone
        if (cs_n_i) begin
            lk_next = lk_reg;
        end
    end

    // Async reset takes constants only
    always_ff @(posedge spi_clk_i or posedge srst_i) begin
        if (srst_i) begin
            lk_reg <= LK_RST;
        end else begin
            lk_reg <= lk_next;
        end
    end

    // Launch on the falling edge
    always_ff @(negedge spi_clk_i or posedge frame_rst) begin
        if (frame_rst) begin
            so_reg <= sfb_pkg::SO_IDLE;
        end else begin
            so_reg <= lk_reg.tx_shift[7];
        end
    end

    //------------------------------------------------------------------
    // Core domain state
    //------------------------------------------------------------------
    always_comb begin
        co_next           = co_reg;
        co_next.rx_valid  = 1'b0;
        co_next.cmd_valid = 1'b0;
        co_next.rx_seen   = rx_co;
        co_next.req_seen  = req_co;
        co_next.frame     = ~cs_n_co;
        // Byte from the link
        if (rx_co != co_reg.rx_seen) begin
            co_next.rx_valid = 1'b1;
            co_next.rx_first = lk_reg.rx_word[8];
            co_next.rx_data  = lk_reg.rx_word[7:0];
            if (lk_reg.rx_word[8]) begin
                co_next.cmd_valid = 1'b1;
                co_next.cmd_class = co_class;
            end
        end
        // Answer echoes the request tag
        if (co_reg.tx_pend && tx_valid_i) begin
            co_next.tx_pend = 1'b0;
            co_next.tx_hold = tx_data_i;
            co_next.ack_tgl = co_reg.req_tag;
        end
        // Deselect drops a stale request
        if (cs_n_co) begin
            co_next.tx_pend   = 1'b0;
            co_next.stat_hold = status_i;
        end
        // New request wins over drop and answer
        if (req_co != co_reg.req_seen) begin
            co_next.tx_pend = 1'b1;
            co_next.req_tag = req_co;
        end
        // Page size switch is sticky
        if (page_pow2_set_i) begin
            co_next.pow2 = 1'b1;
        end
        if (srst_i) begin
            co_next           = '0;
            co_next.stat_hold = sfb_pkg::STAT_RST;
            co_next.pow2      = sfb_pkg::POW2_RST;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        co_reg <= co_next;
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    // Pin released while deselected
    assign so_o      = so_reg;
    assign so_oe_n_o = frame_rst;

    // User side
    assign rx_valid_o     = co_reg.rx_valid;
    assign rx_first_o     = co_reg.rx_first;
    assign rx_data_o      = co_reg.rx_data;
    assign cmd_valid_o    = co_reg.cmd_valid;
    assign cmd_class_o    = co_reg.cmd_class;
    assign tx_req_o       = co_reg.tx_pend;
    assign frame_active_o = co_reg.frame;

    // Default 264, 256 once switched
    assign page_size_o = co_reg.pow2 ? sfb_pkg::PAGE_BYTES_POW2
                                     : sfb_pkg::PAGE_BYTES_DEF;

endmodule // sfb_link

// ===== logic/sfb_pkg.sv
//----------------------------------------------------------------------
// Purpose : Shared constants and types of the serial flash link
// Assumes : Compiled before every sfb_* module
// Notes   : Opcodes, command classes, page sizes, reset values
//----------------------------------------------------------------------
package sfb_pkg;

    //------------------------------------------------------------------
    // Read opcodes
    //------------------------------------------------------------------
    localparam logic [7:0] OP_ARRAY_RD     = 8'h0B;
    localparam logic [7:0] OP_ARRAY_RD_LEG = 8'hE8;
    localparam logic [7:0] OP_ARRAY_RD_LF  = 8'h03;
    localparam logic [7:0] OP_BUF1_RD      = 8'hD4;
    localparam logic [7:0] OP_BUF2_RD      = 8'hD6;
    localparam logic [7:0] OP_BUF1_RD_LF   = 8'hD1;
    localparam logic [7:0] OP_BUF2_RD_LF   = 8'hD3;
    localparam logic [7:0] OP_PAGE_RD      = 8'hD2;
    localparam logic [7:0] OP_PROT_RD      = 8'h32;
    localparam logic [7:0] OP_LOCK_RD      = 8'h35;
    localparam logic [7:0] OP_SEC_RD       = 8'h77;
    localparam logic [7:0] OP_STAT_RD      = 8'hD7;
    localparam logic [7:0] OP_ID_RD        = 8'h9F;

    //------------------------------------------------------------------
    // Command classes
    //------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NONE         = 4'h0,
        CMD_ARRAY_RD     = 4'h1,
        CMD_ARRAY_RD_LEG = 4'h2,
        CMD_ARRAY_RD_LF  = 4'h3,
        CMD_BUF1_RD      = 4'h4,
        CMD_BUF2_RD      = 4'h5,
        CMD_BUF1_RD_LF   = 4'h6,
        CMD_BUF2_RD_LF   = 4'h7,
        CMD_PAGE_RD      = 4'h8,
        CMD_PROT_RD      = 4'h9,
        CMD_LOCK_RD      = 4'hA,
        CMD_SEC_RD       = 4'hB,
        CMD_STAT_RD      = 4'hC,
        CMD_ID_RD        = 4'hD
    } sfb_cmd_e;

    //------------------------------------------------------------------
    // Page sizes, framing and reset values
    //------------------------------------------------------------------
    localparam logic [8:0] PAGE_BYTES_DEF  = 9'h108;
    localparam logic [8:0] PAGE_BYTES_POW2 = 9'h100;
    localparam logic [7:0] FILL_BYTE       = 8'hFF;
    localparam logic [2:0] BIT_LAST        = 3'h7;
    localparam logic [2:0] IDX_MAX         = 3'h7;
    localparam int         ID_LEN_MAX      = 4;
    localparam logic [7:0] STAT_RST        = 8'h00;
    localparam logic       POW2_RST        = 1'b0;
    localparam logic       SO_IDLE         = 1'b1;

endpackage

// ===== logic/sfb_sync.sv
//----------------------------------------------------------------------
// Purpose : Two-stage level synchroniser
// Assumes : Inputs are levels or toggles from another domain
// Notes   : No reset; flushes after two edges of clk_i
//----------------------------------------------------------------------
`timescale 1ns/1ps
module sfb_sync #(
    parameter int W = 1
) (
    // Destination clock
    input  wire logic         clk_i,
    // Level in and synchronised level out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] safe;
    } sfb_sync_s;

    sfb_sync_s st_reg;
    sfb_sync_s st_next;

    if (W < 1) begin : g_chk
        $error("sfb_sync: W must be at least 1");
    end

    // First stage feeds only the second
    always_comb begin
        st_next.meta = d_i;
        st_next.safe = st_reg.meta;
    end

    always_ff @(posedge clk_i) begin
        st_reg <= st_next;
    end

    assign q_o = st_reg.safe;

endmodule // sfb_sync

// ===== logic/sfb_opdec.sv
//----------------------------------------------------------------------
// Purpose : Opcode to command class decoder
// Assumes : Opcode byte complete and stable
// Notes   : Unknown opcodes give CMD_NONE
//----------------------------------------------------------------------
`timescale 1ns/1ps
module sfb_opdec (
    // Opcode byte
    input  wire logic [7:0]   opcode_i,
    // Decoded class
    output sfb_pkg::sfb_cmd_e cmd_class_o
);

    // Table lookup of the read opcodes
    always_comb begin
        unique case (opcode_i)
            sfb_pkg::OP_ARRAY_RD:     cmd_class_o = sfb_pkg::CMD_ARRAY_RD;
            sfb_pkg::OP_ARRAY_RD_LEG: cmd_class_o = sfb_pkg::CMD_ARRAY_RD_LEG;
            sfb_pkg::OP_ARRAY_RD_LF:  cmd_class_o = sfb_pkg::CMD_ARRAY_RD_LF;
            sfb_pkg::OP_BUF1_RD:      cmd_class_o = sfb_pkg::CMD_BUF1_RD;
            sfb_pkg::OP_BUF2_RD:      cmd_class_o = sfb_pkg::CMD_BUF2_RD;
            sfb_pkg::OP_BUF1_RD_LF:   cmd_class_o = sfb_pkg::CMD_BUF1_RD_LF;
            sfb_pkg::OP_BUF2_RD_LF:   cmd_class_o = sfb_pkg::CMD_BUF2_RD_LF;
            sfb_pkg::OP_PAGE_RD:      cmd_class_o = sfb_pkg::CMD_PAGE_RD;
            sfb_pkg::OP_PROT_RD:      cmd_class_o = sfb_pkg::CMD_PROT_RD;
            sfb_pkg::OP_LOCK_RD:      cmd_class_o = sfb_pkg::CMD_LOCK_RD;
            sfb_pkg::OP_SEC_RD:       cmd_class_o = sfb_pkg::CMD_SEC_RD;
            sfb_pkg::OP_STAT_RD:      cmd_class_o = sfb_pkg::CMD_STAT_RD;
            sfb_pkg::OP_ID_RD:        cmd_class_o = sfb_pkg::CMD_ID_RD;
            default:                  cmd_class_o = sfb_pkg::CMD_NONE;
        endcase
    end

endmodule // sfb_opdec

// ===== tb/sfb_link_monitor.sv
//----------------------------------------------------------------------
// Purpose : Port-level checks of the serial flash link
// Assumes : Bound to sfb_link; all checks on the core clock
// Notes   : Serial bit timing is judged by the bench and host model
//----------------------------------------------------------------------
`timescale 1ns/1ps
module sfb_link_monitor #(
    parameter int ID_LEN = 4
) (
    // Core clock and reset
    input wire logic              ref_clk_i,
    input wire logic              srst_i,
    // Serial pins
    input wire logic              cs_n_i,
    input wire logic              so_o,
    input wire logic              so_oe_n_o,
    // User stream
    input wire logic              rx_valid_o,
    input wire logic              rx_first_o,
    input wire logic              cmd_valid_o,
    input sfb_pkg::sfb_cmd_e      cmd_class_o,
    input wire logic              tx_req_o,
    input wire logic              tx_valid_i,
    // Page configuration and frame
    input wire logic              page_pow2_set_i,
    input wire logic [8:0]        page_size_o,
    input wire logic              frame_active_o
);
    //------------------------------------------------------------------
    // Clocking and frame steps
    //------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    // Select edges and the frame flag that follows them
    sequence sel_s;
        $fell(cs_n_i);
    endsequence
    sequence act_s;
        ##[1:4] frame_active_o;
    endsequence
    sequence desel_s;
        $rose(cs_n_i);
    endsequence
    sequence idle_s;
        ##[1:4] !frame_active_o;
    endsequence

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    oe_follow_a: assert property (so_oe_n_o == cs_n_i)
        else $error("output enable does not follow select");
    so_idle_a: assert property (cs_n_i [*4] |-> so_o)
        else $error("serial out not idle while deselected");
    frame_up_a: assert property (sel_s |-> act_s)
        else $error("frame flag late after select");
    frame_down_a: assert property (desel_s |-> idle_s)
        else $error("frame flag late after deselect");
    cmd_first_a: assert property (cmd_valid_o |-> rx_valid_o && rx_first_o)
        else $error("command strobe without opcode byte");
    class_hold_a: assert property ($changed(cmd_class_o) |-> cmd_valid_o)
        else $error("command class moved without strobe");
    rx_pulse_a: assert property (rx_valid_o |=> !rx_valid_o)
        else $error("byte strobe longer than one cycle");
    tx_drop_a: assert property (tx_req_o && tx_valid_i |=> !tx_req_o)
        else $error("byte request not dropped after answer");
    page_set_a: assert property (page_pow2_set_i |-> ##[1:2]
        page_size_o == 9'h100)
        else $error("page size not 256 after set");
    page_keep_a: assert property (page_size_o == 9'h100
        |=> page_size_o == 9'h100)
        else $error("page size left 256 without reset");
    page_def_a: assert property ($fell(srst_i) |-> page_size_o == 9'h108)
        else $error("page size not 264 after reset");
endmodule // sfb_link_monitor

bind sfb_link sfb_link_monitor #(.ID_LEN(ID_LEN)) i_monitor (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .cs_n_i(cs_n_i),
    .so_o(so_o), .so_oe_n_o(so_oe_n_o), .rx_valid_o(rx_valid_o),
    .rx_first_o(rx_first_o), .cmd_valid_o(cmd_valid_o),
    .cmd_class_o(cmd_class_o), .tx_req_o(tx_req_o),
    .tx_valid_i(tx_valid_i), .page_pow2_set_i(page_pow2_set_i),
    .page_size_o(page_size_o), .frame_active_o(frame_active_o)
);

// ===== tb/sfb_host.sv
//----------------------------------------------------------------------
// Purpose : Behavioural bus master driving the serial flash link
// Assumes : 125 ns serial clock, stopped between frames
// Notes : 8 MHz keeps slow reads well inside their limit
//----------------------------------------------------------------------
`timescale 1ns/1ps
module sfb_host (
    // Serial pins driven by the master
    output logic       spi_clk_o,
    output logic       cs_n_o,
    output logic       si_o,
    // Serial pin from the memory
    input  wire logic  so_i
);
    //------------------------------------------------------------------
    // Idle levels
    //------------------------------------------------------------------
    // Deselected just after time zero, before reset is let go
    // The late rise gives the link's select reset an edge to act on
    initial begin
        spi_clk_o = 1'b0;
        si_o      = 1'b1;
        #1 cs_n_o = 1'b1;
    end

    //------------------------------------------------------------------
    // One frame: nbits out MSB first, bits 9..24 of reply captured
    //------------------------------------------------------------------
    // Reads only, so no page rewrites to pace
    task automatic xfer(input logic m3, input int nbits,
                        input logic [23:0] d, output logic [15:0] q);
        q         = 16'h0000;
        spi_clk_o = m3; // Idle level picks mode 0 or 3
        #20;
        cs_n_o = 1'b0;
        si_o   = d[23];
        if (m3) begin
            #20 spi_clk_o = 1'b0;
        end
        for (int r = 1; r <= nbits; r++) begin
            #62.5 spi_clk_o = 1'b1;
            // Next bit launched just after the rising edge
            #1 if (r < nbits) si_o = d[23-r];
            // Reply bit taken just before the next falling edge
            #60 if (r >= 9) q[24-r] = so_i;
            #1.5 spi_clk_o = 1'b0;
        end
        #30 cs_n_o = 1'b1;
        si_o = ~si_o;
        #20 spi_clk_o = m3;
        #60;
    endtask
endmodule // sfb_host

// ===== tb/testbench.sv
//----------------------------------------------------------------------
// Purpose : Self-checking bench of the serial flash link
// Assumes : Core clock 200 MHz, host model on its own clock
// Notes   : Reset first, then opcode table, abort, page and second reset cases
//----------------------------------------------------------------------
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] ID_VAL   = 32'h3C965A12; // Arbitrary value
    localparam logic [7:0]  STAT_VAL = 8'h5C;

    logic              ref_clk  = 1'b0;
    logic              srst;
    logic              spi_clk, cs_n, si, so, so_oe_n;
    logic              rx_valid, rx_first, cmd_valid, tx_req;
    logic              tx_valid = 1'b0;
    logic [7:0]        tx_data  = 8'h00;
    logic [7:0]        status   = STAT_VAL;
    logic              pow2_set = 1'b0;
    logic [7:0]        rx_data;
    logic [8:0]        page_size;
    logic              frame_active;
    sfb_pkg::sfb_cmd_e cmd_class;
    int                mismatches = 0;
    int                n_tests    = 0;
    int                k          = 0;
    logic [15:0]       got;
    // Opcode and expected class, one row each
    logic [11:0]       rows [14] = '{12'h0B1, 12'hE82, 12'h033, 12'hD44,
        12'hD65, 12'hD16, 12'hD37, 12'hD28, 12'h329, 12'h35A, 12'h77B,
        12'hD7C, 12'h9FD, 12'h500};

    //------------------------------------------------------------------
    // Clock, design and host
    //------------------------------------------------------------------
    always #2.5 ref_clk = ~ref_clk;

    sfb_link #(.ID_CODE(ID_VAL), .ID_LEN(1)) i_dut (
        .ref_clk_i(ref_clk), .srst_i(srst), .spi_clk_i(spi_clk),
        .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n),
        .rx_valid_o(rx_valid), .rx_first_o(rx_first),
        .rx_data_o(rx_data), .cmd_valid_o(cmd_valid),
        .cmd_class_o(cmd_class), .tx_req_o(tx_req),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .status_i(status),
        .page_pow2_set_i(pow2_set), .page_size_o(page_size),
        .frame_active_o(frame_active)
    );

    sfb_host i_host (
        .spi_clk_o(spi_clk), .cs_n_o(cs_n), .si_o(si), .so_i(so)
    );

    // Answers byte requests with A1, A2, ... counted per frame
    always @(negedge ref_clk) begin
        if (tx_valid) begin
            tx_valid <= 1'b0;
        end else if (tx_req) begin
            tx_valid <= 1'b1;
            tx_data  <= 8'hA1 + k[7:0];
            k        <= k + 1;
        end
        if (!frame_active) k <= 0;
    end

    //------------------------------------------------------------------
    // Expectations, compares and verdict
    //------------------------------------------------------------------
    function automatic logic [15:0] exp_out(input logic [3:0] c);
        if (c == 4'hC) return {STAT_VAL, STAT_VAL};
        if (c == 4'hD) return {ID_VAL[31:24], 8'hFF};
        return 16'hA1A2;
    endfunction

    task automatic cmp_val(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t value got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmp_cls(input sfb_pkg::sfb_cmd_e g,
                           input sfb_pkg::sfb_cmd_e e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t class got %h exp %h", $time, g, e);
        end
    endtask

    task automatic end_of_test;
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end

    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial begin
        // Reset rises from unknown so the link's async reset sees it
        @(negedge ref_clk);
        srst = 1'b1;
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        cmp_val(page_size, 16'h0108);
        cmp_val(so_oe_n, 16'h0001);
        cmp_val(so, 16'h0001);
        // Every opcode, modes 0 and 3 alternating
        for (int i = 0; i < 14; i++) begin
            i_host.xfer(i[0], 24, {rows[i][11:4], 16'h5AC3}, got);
            repeat (4) @(negedge ref_clk);
            cmp_val(got, exp_out(rows[i][3:0]));
            cmp_cls(cmd_class, sfb_pkg::sfb_cmd_e'(rows[i][3:0]));
            cmp_val(rx_data, 16'h00C3);
        end
        // Frame cut mid-byte, then a full status read
        i_host.xfer(1'b0, 12, 24'hD7A000, got);
        i_host.xfer(1'b1, 24, 24'hD75AC3, got);
        repeat (4) @(negedge ref_clk);
        cmp_val(got, {STAT_VAL, STAT_VAL});
        cmp_cls(cmd_class, sfb_pkg::CMD_STAT_RD);
        // Switch to 256-byte pages, bounded wait for the change
        pow2_set = 1'b1;
        @(negedge ref_clk);
        pow2_set = 1'b0;
        for (int w = 0; w < 8 && page_size !== 9'h100; w++) begin
            @(negedge ref_clk);
        end
        cmp_val(page_size, 16'h0100);
        // Second reset with the bus deselected
        srst = 1'b1;
        repeat (3) @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        cmp_val(page_size, 16'h0108);
        cmp_cls(cmd_class, sfb_pkg::CMD_NONE);
        i_host.xfer(1'b1, 24, 24'h9F5AC3, got);
        repeat (4) @(negedge ref_clk);
        cmp_val(got, {ID_VAL[31:24], 8'hFF});
        end_of_test();
    end
endmodule // testbench
